// ===== inc/apo_pkg.sv
// Purpose: constants for the accelerometer power, offset and command register bank
// Assumes: 8-bit register bus reached through the primary serial slave front end
// Notes:   byte addresses are the printed offsets
// Behaviour
// [R1] three read-write axis trims, reset zero
// [R2] offset-add bit adds trims to samples
// [R3] power save off keeps fast clock
// [R4] power save on uses slow clock idle
// [R5] power config resets with low bits set
// [R6] read option off blocks fifo in save
// [R7] read option on allows fifo after interrupt
// [R8] enable bit 0 switches auxiliary sensor
// [R9] enable bit 2 switches accelerometer, reset zero
// [R10] command register always reads zero
// [R11] store command copies backed registers to memory
// [R12] clear command flushes fifo only
// [R13] software reset restores all defaults; code resets only trims, power_mode_config and sens_en
// [R14] primary interface behaves as bus slave
// [R15] auxiliary master fetches external sensor data
// [R16] unknown command codes are ignored
package apo_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_X_TRIM    = 8'h71;
   localparam logic [7:0] ADDR_Y_TRIM    = 8'h72;
   localparam logic [7:0] ADDR_Z_TRIM    = 8'h73;
   localparam logic [7:0] ADDR_POWER_MODE_CONFIG  = 8'h7C;
   localparam logic [7:0] ADDR_SENS_EN   = 8'h7D;
   localparam logic [7:0] ADDR_CMD       = 8'h7E;
   // ==========================================================
   // reset values and fields
   localparam logic [7:0] RST_TRIM       = 8'h00;
   localparam logic [7:0] RST_POWER_MODE_CONFIG   = 8'h03;
   localparam logic [7:0] RST_SENS_EN    = 8'h00;
   localparam logic [7:0] MASK_POWER_MODE_CONFIG  = 8'h03;
   localparam logic [7:0] MASK_SENS_EN   = 8'h05;
   localparam logic [7:0] READ_ZERO      = 8'h00;
   localparam int         BIT_APS        = 0;
   localparam int         BIT_FSW        = 1;
   localparam int         BIT_AUX_EN     = 0;
   localparam int         BIT_ACC_EN     = 2;
   // ==========================================================
   // command codes
   localparam logic [7:0] CMD_STORE      = 8'hA0;
   localparam logic [7:0] CMD_FLUSH      = 8'hB0;
   localparam logic [7:0] CMD_SOFTRESET  = 8'hB6;
   typedef enum logic [1:0] {APO_CMD_NONE, APO_CMD_STORE, APO_CMD_FLUSH, APO_CMD_RESET} apo_cmd_t;
   typedef enum logic [1:0] {APO_AUX_IDLE, APO_AUX_REQ, APO_AUX_WAIT} apo_aux_t;
endpackage

// ===== inc/apo_sample_if.sv
// Purpose: carries one axis sample and trim between bank and adder
// Assumes: single clock
// Notes:   signed 16-bit samples, signed 8-bit trim
`timescale 1ns/1ns
interface apo_sample_if;
   logic signed [15:0] raw;
   logic signed [15:0] filt;
   logic signed [7:0]  trim;
   logic               add_en;
   logic signed [15:0] raw_out;
   logic signed [15:0] filt_out;
   modport bank  (output raw, filt, trim, add_en, input raw_out, filt_out);
   modport adder (input raw, filt, trim, add_en, output raw_out, filt_out);
endinterface

// ===== design/apo_offset_add.sv
// Purpose: adds one axis trim to raw and filtered sample
// Assumes: samples and trim are two's complement
// Notes:   saturation avoids wrap at full scale
`timescale 1ns/1ns
module apo_offset_add
   import apo_pkg::*;
(
   // clock and reset
   input  wire logic    clk,
   input  wire logic    rst_n,
   // sample path
   apo_sample_if.adder  s
);
   function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                   input logic signed [7:0]  b);
      logic signed [16:0] sum;
      sum = 17'(a) + 17'(b);
      if (sum > 17'sh07FFF)
         return 16'sh7FFF;
      else if (sum < -17'sh08000)
         return -16'sh8000;
      else
         return sum[15:0];
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s.raw_out  <= 16'h0000;
         s.filt_out <= 16'h0000;
      end else begin
         s.raw_out  <= s.add_en ? sat_add(s.raw, s.trim) : s.raw;   // [R2]
         s.filt_out <= s.add_en ? sat_add(s.filt, s.trim) : s.filt; // [R2]
      end
   end

   property p_add;
      @(posedge clk) disable iff (!rst_n)
      s.add_en && $past(s.add_en) |=> s.raw_out == sat_add($past(s.raw), $past(s.trim));
   endproperty
   a_add : assert property (p_add) else $error("offset not added"); // [R2]
endmodule

// ===== design/apo_regs.sv
// Purpose: power, offset and command register bank of the accelerometer
// Assumes: serial slave front end delivers one-cycle read and write strobes
// Notes:   non-volatile image kept in flops; programming sequence is outside
`timescale 1ns/1ns
module apo_regs
   import apo_pkg::*;
#(
   parameter int AXES = 3
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // register access from primary slave interface
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   output logic      [7:0]             reg_rdata,
   // configuration from neighbouring registers
   input  wire logic                   offset_add_en,
   input  wire logic                   measuring,
   input  wire logic                   int_event,
   // samples in and out
   input  wire logic [AXES*16-1:0]     raw_in,
   input  wire logic [AXES*16-1:0]     filt_in,
   output logic      [AXES*16-1:0]     raw_out,
   output logic      [AXES*16-1:0]     filt_out,
   // power and fifo control
   output logic                        fast_clk_en,
   output logic                        slow_clk_sel,
   output logic                        fifo_rd_allow,
   output logic                        fifo_flush,
   output logic                        acc_on,
   output logic                        aux_on,
   // non-volatile store and reset
   output logic                        nvm_store,
   output logic      [AXES*8-1:0]      nvm_image,
   output logic                        soft_reset,
   // auxiliary sensor master
   output logic                        aux_req,
   input  wire logic                   aux_ack,
   input  wire logic [15:0]            aux_rdata,
   output logic      [15:0]            aux_data
);
   // ==========================================================
   // storage
   logic [7:0]    trim [AXES];
   logic [7:0]    power_mode_config;
   logic [7:0]    sens_en;
   logic          wake_pending;
   apo_cmd_t      cmd_dec;
   apo_aux_t      aux_state;

   function automatic apo_cmd_t decode_cmd(input logic [7:0] code);
      case (code)
         CMD_STORE:     return APO_CMD_STORE;
         CMD_FLUSH:     return APO_CMD_FLUSH;
         CMD_SOFTRESET: return APO_CMD_RESET;
         default:       return APO_CMD_NONE;
      endcase
   endfunction

   wire logic cmd_wr = reg_wr && reg_addr == ADDR_CMD;
   always_comb begin
      cmd_dec = cmd_wr ? decode_cmd(reg_wdata) : APO_CMD_NONE; // [R16]
   end
   wire logic sw_rst = cmd_dec == APO_CMD_RESET;

   // ==========================================================
   // writes; software reset restores defaults in the next cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < AXES; i++) begin
            trim[i] <= RST_TRIM; // [R1]
         end
      end else if (sw_rst) begin
         for (int i = 0; i < AXES; i++) begin
            trim[i] <= RST_TRIM; // [R13]
         end
      end else if (reg_wr) begin
         for (int i = 0; i < AXES; i++) begin
            if (reg_addr == ADDR_X_TRIM + 8'(i))
               trim[i] <= reg_wdata; // [R1]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_mode_config <= RST_POWER_MODE_CONFIG; // [R5]
         sens_en  <= RST_SENS_EN;  // [R9]
      end else if (sw_rst) begin
         power_mode_config <= RST_POWER_MODE_CONFIG; // [R13]
         sens_en  <= RST_SENS_EN;  // [R13]
      end else if (reg_wr) begin
         if (reg_addr == ADDR_POWER_MODE_CONFIG)
            power_mode_config <= reg_wdata & MASK_POWER_MODE_CONFIG;
         if (reg_addr == ADDR_SENS_EN)
            sens_en <= reg_wdata & MASK_SENS_EN; // [R8] [R9]
      end
   end

   // ==========================================================
   // read mux; reserved bits and command read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= READ_ZERO;
      end else if (reg_rd) begin // [R14]
         case (reg_addr)
            ADDR_X_TRIM:   reg_rdata <= trim[0];
            ADDR_Y_TRIM:   reg_rdata <= trim[1];
            ADDR_Z_TRIM:   reg_rdata <= trim[2];
            ADDR_POWER_MODE_CONFIG: reg_rdata <= power_mode_config;
            ADDR_SENS_EN:  reg_rdata <= sens_en;
            ADDR_CMD:      reg_rdata <= READ_ZERO; // [R10]
            default:       reg_rdata <= READ_ZERO;
         endcase
      end
   end

   // ==========================================================
   // commands: one-cycle pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm_store  <= 1'b0;
         fifo_flush <= 1'b0;
         soft_reset <= 1'b0;
         nvm_image  <= '0;
      end else begin
         nvm_store  <= cmd_dec == APO_CMD_STORE; // [R11]
         fifo_flush <= cmd_dec == APO_CMD_FLUSH; // [R12]
         soft_reset <= sw_rst;                   // [R13]
         if (cmd_dec == APO_CMD_STORE) begin
            for (int i = 0; i < AXES; i++) begin
               nvm_image[i*8 +: 8] <= trim[i]; // [R11]
            end
         end
      end
   end

   // ==========================================================
   // power save clocking and fifo read gating
   wire logic aps = power_mode_config[BIT_APS];
   wire logic fsw = power_mode_config[BIT_FSW];
   wire logic in_save = aps && !measuring;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_pending <= 1'b0;
      end else if (int_event) begin
         wake_pending <= 1'b1; // set wins over clear
      end else if (!in_save || fifo_flush) begin
         wake_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_clk_en   <= 1'b1;
         slow_clk_sel  <= 1'b0;
         fifo_rd_allow <= 1'b1;
         acc_on        <= 1'b0;
         aux_on        <= 1'b0;
      end else begin
         fast_clk_en   <= !in_save;                          // [R3] [R4]
         slow_clk_sel  <= in_save;                           // [R4]
         fifo_rd_allow <= !in_save || (fsw && wake_pending); // [R6] [R7]
         acc_on        <= sens_en[BIT_ACC_EN];               // [R9]
         aux_on        <= sens_en[BIT_AUX_EN];               // [R8]
      end
   end

   // ==========================================================
   // auxiliary master: polls external sensor while enabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_state <= APO_AUX_IDLE;
         aux_req   <= 1'b0;
         aux_data  <= 16'h0000;
      end else begin
         case (aux_state)
            APO_AUX_IDLE: begin
               if (aux_on) begin
                  aux_state <= APO_AUX_REQ; // [R15]
               end
            end
            APO_AUX_REQ: begin
               aux_req   <= 1'b1;
               aux_state <= APO_AUX_WAIT;
            end
            APO_AUX_WAIT: begin
               if (aux_ack) begin
                  aux_req   <= 1'b0;
                  aux_data  <= aux_rdata; // [R15]
                  aux_state <= APO_AUX_IDLE;
               end
            end
            default: aux_state <= APO_AUX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // offset adders per axis
   for (genvar g = 0; g < AXES; g++) begin : g_axis
      apo_sample_if sif ();
      assign sif.raw    = raw_in[g*16 +: 16];
      assign sif.filt   = filt_in[g*16 +: 16];
      assign sif.trim   = trim[g];
      assign sif.add_en = offset_add_en; // [R2]
      assign raw_out[g*16 +: 16]  = sif.raw_out;
      assign filt_out[g*16 +: 16] = sif.filt_out;
      apo_offset_add u_add (
         .clk   (clk),
         .rst_n (rst_n),
         .s     (sif)
      );
   end

   // ==========================================================
   // checks
   sequence s_wake_seen;
      in_save && fsw && int_event;
   endsequence

   // the wake must survive a cycle of unchanged save settings
   sequence s_still_saving;
      in_save && fsw;
   endsequence

   property p_trim_wr;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_X_TRIM |=> trim[0] == $past(reg_wdata);
   endproperty
   a_trim_wr : assert property (p_trim_wr) else $error("trim write lost"); // [R1]

   property p_fast;
      @(posedge clk) disable iff (!rst_n)
      !aps |=> fast_clk_en && !slow_clk_sel;
   endproperty
   a_fast : assert property (p_fast) else $error("fast clock stopped"); // [R3]

   property p_slow;
      @(posedge clk) disable iff (!rst_n)
      aps && !measuring |=> slow_clk_sel && !fast_clk_en;
   endproperty
   a_slow : assert property (p_slow) else $error("slow clock not used"); // [R4]

   property p_rst_cfg;
      @(posedge clk) disable iff (!rst_n)
      sw_rst |=> power_mode_config == RST_POWER_MODE_CONFIG && sens_en == RST_SENS_EN && trim[1] == RST_TRIM;
   endproperty
   a_rst_cfg : assert property (p_rst_cfg) else $error("defaults not restored"); // [R13]

   property p_fifo_block;
      @(posedge clk) disable iff (!rst_n)
      in_save && !fsw |=> !fifo_rd_allow;
   endproperty
   a_fifo_block : assert property (p_fifo_block) else $error("fifo read in save"); // [R6]

   property p_fifo_wake;
      @(posedge clk) disable iff (!rst_n)
      s_wake_seen ##1 s_still_saving |=> fifo_rd_allow;
   endproperty
   a_fifo_wake : assert property (p_fifo_wake) else $error("fifo read not woken"); // [R7]

   property p_aux_en;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_SENS_EN && !sw_rst
         |=> ##1 aux_on == $past(reg_wdata[BIT_AUX_EN], 2);
   endproperty
   a_aux_en : assert property (p_aux_en) else $error("aux enable wrong"); // [R8]

   property p_acc_en;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_SENS_EN && !sw_rst
         |=> ##1 acc_on == $past(reg_wdata[BIT_ACC_EN], 2);
   endproperty
   a_acc_en : assert property (p_acc_en) else $error("acc enable wrong"); // [R9]

   property p_cmd_zero;
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_CMD |=> reg_rdata == READ_ZERO;
   endproperty
   a_cmd_zero : assert property (p_cmd_zero) else $error("command read nonzero"); // [R10]

   property p_store;
      @(posedge clk) disable iff (!rst_n)
      cmd_wr && reg_wdata == CMD_STORE |=> nvm_store && nvm_image[7:0] == trim[0];
   endproperty
   a_store : assert property (p_store) else $error("store missed"); // [R11]

   property p_flush;
      @(posedge clk) disable iff (!rst_n)
      cmd_wr && reg_wdata == CMD_FLUSH |=> fifo_flush && !nvm_store && !soft_reset;
   endproperty
   a_flush : assert property (p_flush) else $error("flush missed"); // [R12]

   property p_ignore;
      @(posedge clk) disable iff (!rst_n)
      cmd_wr && cmd_dec == APO_CMD_NONE |=> !nvm_store && !fifo_flush && !soft_reset;
   endproperty
   a_ignore : assert property (p_ignore) else $error("unknown command acted"); // [R16]

   property p_aux_fetch;
      @(posedge clk) disable iff (!rst_n)
      aux_state == APO_AUX_WAIT && aux_ack |=> aux_data == $past(aux_rdata);
   endproperty
   a_aux_fetch : assert property (p_aux_fetch) else $error("aux data not captured"); // [R15]
endmodule

// ===== verification/apo_aux_sensor_model.sv
// Purpose: auxiliary sensor stand-in answering the bank's fetch handshake
// Assumes: one clock shared with the bank
// Notes:   alternates prompt and slow answers; data lines churn when idle
`timescale 1ns/1ns
module apo_aux_sensor_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // fetch handshake
   input  wire logic        aux_req,
   output logic             aux_ack,
   output logic [15:0]      aux_rdata,
   // value to hand out
   input  wire logic [15:0] word
);
   // ==========================================================
   // answer logic
   int   wait_n;
   logic slow;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_ack   <= 1'b0;
         aux_rdata <= 16'h0000;
         wait_n    <= 0;
         slow      <= 1'b0;
      end else if (aux_ack) begin
         aux_ack   <= 1'b0;
         aux_rdata <= ~word;
         wait_n    <= 0;
         slow      <= ~slow;
      end else if (aux_req === 1'b1 && wait_n >= (slow ? 5 : 0)) begin
         aux_ack   <= 1'b1;
         aux_rdata <= word;
      end else begin
         // idle lines churn so a capture off the ack edge cannot match by luck
         aux_rdata <= aux_rdata + 16'h9E37;
         wait_n    <= aux_req ? wait_n + 1 : 0;
      end
   end
endmodule

// ===== verification/test_accel_power_offset_command_regs.sv
// Purpose: self-checking bench for the power, offset and command bank
// Assumes: single 125 MHz clock, asynchronous active-low reset
// Notes:   reads are checked through an expectation queue by a monitor
`timescale 1ns/1ns
module test_accel_power_offset_command_regs;
   logic        clk, rst_n, reg_wr, reg_rd, offset_add_en, measuring, int_event;
   logic        fast_clk_en, slow_clk_sel, fifo_rd_allow, fifo_flush, acc_on, aux_on;
   logic        nvm_store, soft_reset, aux_req, aux_ack, rd_d;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [47:0] raw_in, filt_in, raw_out, filt_out, rin, fin, er, ef;
   logic [23:0] nvm_image;
   logic [15:0] aux_rdata, aux_data, word, rv, fv;
   logic [7:0]  exp_q[$];
   logic [7:0]  tr[3];
   logic [6:0]  tbl[6];
   logic [31:0] lf;
   logic [3:0]  n_st, n_fl, n_rs;
   int          fail_count, checked, cyc, a, k;
   // ==========================================================
   // design and far side
   apo_regs #(.AXES(3)) i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .offset_add_en(offset_add_en), .measuring(measuring), .int_event(int_event),
      .raw_in(raw_in), .filt_in(filt_in), .raw_out(raw_out), .filt_out(filt_out),
      .fast_clk_en(fast_clk_en), .slow_clk_sel(slow_clk_sel), .fifo_rd_allow(fifo_rd_allow),
      .fifo_flush(fifo_flush), .acc_on(acc_on), .aux_on(aux_on), .nvm_store(nvm_store),
      .nvm_image(nvm_image), .soft_reset(soft_reset), .aux_req(aux_req), .aux_ack(aux_ack),
      .aux_rdata(aux_rdata), .aux_data(aux_data));
   apo_aux_sensor_model i_aux (.clk(clk), .rst_n(rst_n), .aux_req(aux_req),
      .aux_ack(aux_ack), .aux_rdata(aux_rdata), .word(word));
   // ==========================================================
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // counts pulses over a fixed window, so the exact pulse edge is left open
   task automatic issue(input logic [7:0] c, input logic [11:0] e);
      @(negedge clk);
      n_st = 4'h0;
      n_fl = 4'h0;
      n_rs = 4'h0;
      wr(8'h7E, c);
      repeat (4) @(posedge clk);
      #1 chk({n_st, n_fl, n_rs}, e);
   endtask
   task automatic pw(input logic [6:0] t);
      wr(8'h7C, {6'h00, t[6:5]});
      measuring <= t[4];
      int_event <= t[3];
      @(posedge clk);
      int_event <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk({fast_clk_en, slow_clk_sel, fifo_rd_allow}, t[2:0]);
   endtask
   task automatic waitaux(input logic [15:0] w);
      int n;
      n = 0;
      while (aux_data !== w && n < 64) begin
         @(negedge clk);
         n++;
      end
      chk(aux_data, w);
   endtask
   // ==========================================================
   // monitors and timeout
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (nvm_store === 1'b1) n_st++;
      if (fifo_flush === 1'b1) n_fl++;
      if (soft_reset === 1'b1) n_rs++;
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         conclude();
      end
   end
   always @(negedge clk) begin
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) chk(48'h1_0000_0000, {40'h0, reg_rdata});
         else chk(reg_rdata, exp_q.pop_front());
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, offset_add_en, measuring, int_event, rd_d} = 7'h00;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      raw_in = 48'h0;
      filt_in = 48'h0;
      word = 16'hC3A5;
      lf = 32'h1619;
      tbl = '{7'h62, 7'h6B, 7'h75, 7'h62, 7'h2A, 7'h05};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (a = 0; a < 3; a++) rd(8'(8'h71 + a), 8'h00);
      rd(8'h7C, 8'h03);
      rd(8'h7D, 8'h00);
      rd(8'h7E, 8'h00);
      rd(8'h70, 8'h00);
      wr(8'h7C, 8'hFF);
      wr(8'h7D, 8'hFA);
      rd(8'h7C, 8'h03);
      rd(8'h7D, 8'h00);
      for (a = 0; a < 3; a++) begin
         lf = nxt(lf);
         tr[a] = lf[7:0];
         wr(8'(8'h71 + a), tr[a]);
      end
      for (a = 0; a < 3; a++) rd(8'(8'h71 + a), tr[a]);
      $display("test registers done");
      for (k = 0; k < 4; k++) begin
         for (a = 0; a < 3; a++) begin
            lf = nxt(lf);
            rv = {{3{lf[12]}}, lf[12:0]};
            fv = {{3{lf[28]}}, lf[28:16]};
            rin[a*16+:16] = rv;
            fin[a*16+:16] = fv;
            er[a*16+:16] = k[0] ? rv + {{8{tr[a][7]}}, tr[a]} : rv;
            ef[a*16+:16] = k[0] ? fv + {{8{tr[a][7]}}, tr[a]} : fv;
         end
         @(posedge clk);
         raw_in <= rin;
         filt_in <= fin;
         offset_add_en <= k[0];
         repeat (2) @(posedge clk);
         #1 chk(raw_out, er);
         chk(filt_out, ef);
      end
      tr[0] = 8'h7F;
      wr(8'h71, tr[0]);
      raw_in[15:0] <= 16'h7FFF;
      repeat (2) @(posedge clk);
      #1 chk(raw_out[15:0], 16'h7FFF);
      $display("test samples done");
      issue(8'hA0, 12'h100);
      chk(nvm_image, {tr[2], tr[1], tr[0]});
      issue(8'hB0, 12'h010);
      foreach (tbl[a]) issue(8'(a * 8'h2D + 8'h55), 12'h000);
      for (a = 0; a < 3; a++) rd(8'(8'h71 + a), tr[a]);
      rd(8'h7E, 8'h00);
      wr(8'h7D, 8'h05);
      wr(8'h7C, 8'h00);
      issue(8'hB6, 12'h001);
      for (a = 0; a < 3; a++) rd(8'(8'h71 + a), 8'h00);
      rd(8'h7C, 8'h03);
      rd(8'h7D, 8'h00);
      chk({acc_on, aux_on}, 2'h0);
      $display("test commands done");
      wr(8'h7D, 8'h01);
      repeat (3) @(posedge clk);
      #1 chk({acc_on, aux_on}, 2'h1);
      waitaux(16'hC3A5);
      @(posedge clk);
      word <= 16'h5A3C;
      waitaux(16'h5A3C);
      wr(8'h7D, 8'h04);
      repeat (3) @(posedge clk);
      #1 chk({acc_on, aux_on}, 2'h2);
      wr(8'h7D, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk({acc_on, aux_on}, 2'h0);
      $display("test sensors done");
      foreach (tbl[a]) pw(tbl[a]);
      $display("test power done");
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule
